// >>> hw/fx_rx_pcs.v
// Purpose: receive coding sublayer: nrzi, descramble, align, decode
// Assumes: line bits arrive with a bit_valid strobe from the recovery path
// Notes:   mii output stalls via a two-entry buffer; no 10 Mb/s logic
`timescale 1ns/100ps
`include "fx_rx_pcs_map.vh"

// Contract
// - loop filter yields signed 8-bit frequency word
// - deliver 5-bit symbols to receive state machine
// - descramble by xor with local key
// - sync after twelve consecutive idles
// - start hold countdown, restart on idle run
// - countdown expiry drops sync, resets descrambler
// - extend control selects two millisecond hold
// - align code-groups on start delimiter pair
// - start delimiter pair becomes preamble nibbles
// - lookup decode until end pair or idles
// - link up after signal detect 395 us
// - bad start: error with nibble 1110
// - each bad start adds one to counter
// - two idles end error and carrier
// - fiber mode from strap or register
// - fiber transmit bypasses scrambler, sends nrzi
// - fiber receive bypasses descrambler
// - no signal in fiber sends fault pattern
// - detected fault pattern forces link down
// - control codes inside packet are invalid
// - end pair is 01101 then 00111
// - key from 11-bit closed-loop lfsr
module fx_rx_pcs (
  input  wire        mclk,
  input  wire        arst_n,
  input  wire        bit_valid,
  input  wire        rx_line,
  input  wire        sig_detect,
  input  wire        fiber_strap,
  input  wire        fiber_reg,
  input  wire        fiber_reg_sel,
  input  wire        descrambler_timeout_extend,
  input  wire        phase_err_valid,
  input  wire signed [7:0] phase_err,
  input  wire        tx_bit_valid,
  input  wire        tx_line_in,
  input  wire        mii_ready,
  output wire        mii_valid,
  output wire [3:0]  rxd,
  output wire        rx_dv,
  output wire        rx_er,
  output reg         crs,
  output reg         link_up,
  output reg         descr_locked,
  output reg         fiber_mode,
  output reg  [15:0] false_carrier_counter,
  output reg  signed [7:0] freq_ctrl,
  output reg         tx_line_out,
  output wire        stall
);
  // ****************************************************************
  // input synchronisers and helpers
  // ****************************************************************
  localparam [31:0] HOLD_S = `HOLD_SHORT_CYC;
  localparam [31:0] HOLD_L = `HOLD_LONG_CYC;
  localparam [31:0] LUP    = `LINK_UP_CYC;
  localparam [1:0]  ST_IDLE = 2'h0, ST_PKT = 2'h1, ST_BAD = 2'h2, ST_END = 2'h3;

  reg [1:0] sd_s, rx_s, bv_s;
  wire      sdet = sd_s[1];
  wire      rxb  = rx_s[1];
  wire      bv   = bv_s[1];

  function [4:0] dec5; // returns {invalid, nibble}
    input [4:0] c;
    begin
      case (c)
        5'h1e: dec5 = 5'h00; 5'h09: dec5 = 5'h01; 5'h14: dec5 = 5'h02;
        5'h15: dec5 = 5'h03; 5'h0a: dec5 = 5'h04; 5'h0b: dec5 = 5'h05;
        5'h0e: dec5 = 5'h06; 5'h0f: dec5 = 5'h07; 5'h12: dec5 = 5'h08;
        5'h13: dec5 = 5'h09; 5'h16: dec5 = 5'h0a; 5'h17: dec5 = 5'h0b;
        5'h1a: dec5 = 5'h0c; 5'h1b: dec5 = 5'h0d; 5'h1c: dec5 = 5'h0e;
        5'h1d: dec5 = 5'h0f;
        default: dec5 = 5'h1e; // control or unassigned: invalid
      endcase
    end
  endfunction

  // detect, line and bit strobe inputs pass two flip-flops before any use
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sd_s <= 2'h0;
      rx_s <= 2'h0;
      bv_s <= 2'h0;
    end else begin
      sd_s <= {sd_s[0], sig_detect};
      rx_s <= {rx_s[0], rx_line};
      bv_s <= {bv_s[0], bit_valid};
    end
  end

  // ****************************************************************
  // mode, loop filter, nrzi, descrambler
  // ****************************************************************
  reg         strap_q, strap_done_q, prev_q;
  reg  [10:0] lfsr_q;
  reg  [4:0]  win_q;
  reg  [3:0]  idle_cnt_q;
  reg  [2:0]  ph_q;
  reg  [31:0] hold_q;
  reg  [6:0]  idle_run_q;
  wire        nrz  = rxb ^ prev_q;
  wire        key  = lfsr_q[10] ^ lfsr_q[8];
  wire        ud   = fiber_mode ? nrz : (nrz ^ key);
  wire [4:0]  win_d = {win_q[3:0], ud};
  wire [31:0] hold_len = descrambler_timeout_extend ? HOLD_L : HOLD_S;

  // strap caught once after reset release, register can override
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      strap_q      <= 1'b0;
      strap_done_q <= 1'b0;
      fiber_mode   <= 1'b0;
      freq_ctrl    <= 8'sh00;
    end else begin
      if (!strap_done_q) begin
        strap_q      <= fiber_strap;
        strap_done_q <= 1'b1;
      end
      fiber_mode <= fiber_reg_sel ? fiber_reg : strap_q;
      // first-order integrator with saturation
      if (phase_err_valid) begin
        if (phase_err > 0 && freq_ctrl == 8'sh7f)
          freq_ctrl <= freq_ctrl;
        else if (phase_err < 0 && freq_ctrl == -8'sh80)
          freq_ctrl <= freq_ctrl;
        else if (phase_err > 0)
          freq_ctrl <= freq_ctrl + 8'sh01;
        else if (phase_err < 0)
          freq_ctrl <= freq_ctrl - 8'sh01;
      end
    end
  end

  // serial path: descrambler lfsr, sync search and hold timer
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prev_q       <= 1'b0;
      lfsr_q       <= 11'h7ff;
      win_q        <= 5'h0;
      idle_cnt_q   <= 4'h0;
      ph_q         <= 3'h0;
      hold_q       <= 32'h0;
      idle_run_q   <= 7'h0;
      descr_locked <= 1'b0;
    end else begin
      if (bv) begin
        prev_q <= rxb;
        win_q  <= win_d;
        // closed loop: key regenerated from local state once locked
        if (descr_locked || fiber_mode)
          lfsr_q <= {lfsr_q[9:0], key};
        else
          lfsr_q <= {lfsr_q[9:0], nrz ^ 1'b1};    // idles assumed
        if (!descr_locked && !fiber_mode) begin
          ph_q   <= (ph_q == 3'h4) ? 3'h0 : ph_q + 3'h1;
          if (ph_q == 3'h4)
            idle_cnt_q <= (win_d == `CG_IDLE) ? idle_cnt_q + 4'h1 : 4'h0;
          if (ph_q == 3'h4 && win_d == `CG_IDLE && idle_cnt_q == 4'd11) begin
            descr_locked <= 1'b1;
            hold_q       <= hold_len;
          end
        end
        if (descr_locked)
          idle_run_q <= ud ? ((idle_run_q == 7'd127) ? idle_run_q
                                                     : idle_run_q + 7'h1) : 7'h0;
      end
      if (descr_locked) begin
        if (idle_run_q >= `IDLE_RUN_BITS) begin
          hold_q     <= hold_len;
          idle_run_q <= 7'h0;
        end else if (hold_q == 32'h0) begin
          descr_locked <= 1'b0;
          lfsr_q       <= 11'h7ff;
          idle_cnt_q   <= 4'h0;
          ph_q         <= 3'h0;
        end else
          hold_q <= hold_q - 32'h1;
      end
    end
  end

  // ****************************************************************
  // alignment, decode, link monitor, far-end fault
  // ****************************************************************
  reg  [1:0]  st_q;
  reg         aligned_q, sym_v_q, jk_q, first_q;
  reg  [1:0]  pend_q;
  reg  [2:0]  bitc_q;
  reg  [4:0]  sym_q, last_q;
  reg  [1:0]  idles_q;
  reg  [31:0] lup_q;
  reg  [6:0]  fef_ones_q;
  reg  [1:0]  fef_rep_q;
  reg         fef_seen_q;
  reg  [6:0]  tx_ones_q;
  reg  [5:0]  push_dat;
  reg         push_v;
  wire        buf_rdy;
  wire        path_ok = descr_locked | fiber_mode;
  wire [4:0]  dv      = dec5(sym_q);

  assign stall = ~buf_rdy;

  // framing: a new 5-bit boundary is set by a j after idles
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      aligned_q <= 1'b0;
      bitc_q    <= 3'h0;
      sym_q     <= 5'h1f;
      last_q    <= 5'h00;
      pend_q    <= 2'h0;
      sym_v_q   <= 1'b0;
      jk_q      <= 1'b0;
    end else begin
      sym_v_q <= 1'b0;
      jk_q    <= 1'b0;
      if (bv && path_ok && buf_rdy) begin
        if (st_q == ST_IDLE && last_q == `CG_IDLE && win_d == `CG_J) begin
          aligned_q <= 1'b1;
          bitc_q    <= 3'h0;
          pend_q    <= 2'h0;
          last_q    <= win_d;
        end else if (aligned_q) begin
          bitc_q <= (bitc_q == 3'h4) ? 3'h0 : bitc_q + 3'h1;
          if (bitc_q == 3'h4) begin
            sym_q   <= win_d;
            sym_v_q <= 1'b1;
          end
        end else if (pend_q == 2'h2) begin
          // first zero now sits where j has it and no j: bad start,
          // framed on this window so later groups are judged one by one
          sym_q     <= win_d;
          sym_v_q   <= 1'b1;
          aligned_q <= 1'b1;
          bitc_q    <= 3'h0;
          pend_q    <= 2'h0;
          last_q    <= win_d;
        end else if (pend_q != 2'h0) begin
          pend_q <= pend_q + 2'h1;
        end else if (win_d == `CG_IDLE) begin
          last_q <= `CG_IDLE;
        end else if (win_q == `CG_IDLE) begin
          pend_q <= 2'h1;      // first zero after idles: wait for a j
        end
        if (st_q == ST_IDLE && last_q == `CG_IDLE && win_d == `CG_J)
          jk_q <= 1'b1;
      end
      if (st_q == ST_IDLE && sym_v_q && sym_q == `CG_IDLE) begin
        aligned_q <= 1'b0;
        last_q    <= `CG_IDLE;
      end
    end
  end

  // receive state machine with mii nibble generation
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q                  <= ST_IDLE;
      idles_q               <= 2'h0;
      crs                   <= 1'b0;
      false_carrier_counter <= 16'h0;
      push_v                <= 1'b0;
      push_dat              <= 6'h0;
      first_q               <= 1'b0;
    end else begin
      push_v <= 1'b0;
      if (!link_up || !path_ok) begin
        st_q <= ST_IDLE;
        crs  <= 1'b0;
      end else if (jk_q) begin
        st_q <= ST_PKT;   // k framed next, both become preamble
        crs  <= 1'b1;
        first_q  <= 1'b1;
        push_v   <= 1'b1;
        push_dat <= {1'b0, 1'b1, `NIB_PREAMBLE};
      end else if (sym_v_q) begin
        case (st_q)
          ST_IDLE: begin
            if (sym_q != `CG_IDLE) begin
              st_q <= ST_BAD;
              crs  <= 1'b1;
              idles_q <= 2'h0;
              false_carrier_counter <= false_carrier_counter + 16'h1;
              push_v   <= 1'b1;
              push_dat <= {1'b1, 1'b0, `NIB_BAD_SSD};
            end
          end
          ST_PKT: begin
            idles_q <= (sym_q == `CG_IDLE) ? idles_q + 2'h1 : 2'h0;
            first_q <= 1'b0;
            // only the group right after j is the k; a later k is invalid
            if (first_q && sym_q == `CG_K) begin
              push_v   <= 1'b1;
              push_dat <= {1'b0, 1'b1, `NIB_PREAMBLE};
            end else if (sym_q == `CG_T) begin
              st_q <= ST_END;              // t alone ends stream, next group not checked
              crs  <= 1'b0;
            end else if (sym_q == `CG_IDLE && idles_q == 2'h1) begin
              st_q <= ST_IDLE;
              crs  <= 1'b0;
            end else begin
              push_v   <= 1'b1;
              push_dat <= {dv[4], 1'b1, dv[3:0]};
            end
          end
          ST_BAD: begin
            idles_q <= (sym_q == `CG_IDLE) ? idles_q + 2'h1 : 2'h0;
            if (sym_q == `CG_IDLE && idles_q == 2'h1) begin
              st_q <= ST_IDLE;
              crs  <= 1'b0;
            end else begin
              push_v   <= 1'b1;
              push_dat <= {1'b1, 1'b0, `NIB_BAD_SSD};
            end
          end
          ST_END: st_q <= ST_IDLE;         // r absorbed, not a bad start
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // link monitor, fault detect and fiber fault transmit
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lup_q       <= 32'h0;
      link_up     <= 1'b0;
      fef_ones_q  <= 7'h0;
      fef_rep_q   <= 2'h0;
      fef_seen_q  <= 1'b0;
      tx_ones_q   <= 7'h0;
      tx_line_out <= 1'b0;
    end else begin
      if (!sdet || fef_seen_q) begin
        lup_q   <= 32'h0;
        link_up <= 1'b0;
      end else if (lup_q >= LUP - 32'h1)
        link_up <= 1'b1;
      else
        lup_q <= lup_q + 32'h1;
      // 84 ones then a zero, three in a row, counts as fault
      if (bv && fiber_mode) begin
        if (nrz)
          fef_ones_q <= (fef_ones_q == 7'd127) ? fef_ones_q : fef_ones_q + 7'h1;
        else begin
          fef_ones_q <= 7'h0;
          if (fef_ones_q == `FEF_ONES) begin
            fef_rep_q <= (fef_rep_q == 2'h3) ? fef_rep_q : fef_rep_q + 2'h1;
            if (fef_rep_q >= `FEF_REPEATS - 1)
              fef_seen_q <= 1'b1;
          end else begin
            fef_rep_q  <= 2'h0;
            fef_seen_q <= 1'b0;
          end
        end
      end
      // fiber tx: nrzi pattern sent direct, no scrambling
      if (tx_bit_valid) begin
        if (fiber_mode && !sdet) begin
          tx_ones_q   <= (tx_ones_q == `FEF_ONES) ? 7'h0 : tx_ones_q + 7'h1;
          tx_line_out <= tx_line_out ^ (tx_ones_q != `FEF_ONES);
        end else begin
          tx_ones_q   <= 7'h0;
          tx_line_out <= tx_line_in;
        end
      end
    end
  end

  // output buffer: receiver stall freezes framing, no nibble lost
  skid_buf2 #(.W(6)) u_buf (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .in_valid  (push_v),
    .in_ready  (buf_rdy),
    .in_data   (push_dat),
    .out_valid (mii_valid),
    .out_ready (mii_ready),
    .out_data  ({rx_er, rx_dv, rxd})
  );
endmodule // fx_rx_pcs

// >>> hw/fx_rx_pcs_map.vh
// Purpose: constants for the 100 Mb/s receive coding sublayer
// Assumes: mclk at 250 MHz, one line bit offered per bit_valid pulse
// Notes:   times kept in their own unit, cycle counts derived from them
`ifndef FX_RX_PCS_MAP_VH
`define FX_RX_PCS_MAP_VH

// ********************************************************************
// timing
// ********************************************************************
`define CLK_MHZ            250
`define HOLD_SHORT_US      722
`define HOLD_LONG_US       2000
`define LINK_UP_US         395
`define HOLD_SHORT_CYC     (`HOLD_SHORT_US * `CLK_MHZ)
`define HOLD_LONG_CYC      (`HOLD_LONG_US * `CLK_MHZ)
`define LINK_UP_CYC        (`LINK_UP_US * `CLK_MHZ)
`define IDLE_RUN_BITS      58
`define SYNC_IDLES         12
`define FEF_ONES           84
`define FEF_REPEATS        3

// ********************************************************************
// code-groups and nibbles
// ********************************************************************
`define CG_IDLE            5'h1f
`define CG_J               5'h18
`define CG_K               5'h11
`define CG_T               5'h0d
`define CG_R               5'h07
`define NIB_PREAMBLE       4'h5
`define NIB_BAD_SSD        4'he
`define NIB_ZERO           4'h0

// ********************************************************************
// configuration bit position, register address and widths
// ********************************************************************
`define CFG_TIMEOUT_EXT    7
`define CFG_ADDR           5'h16
`define LFSR_W             11
`define FCC_W              16

`endif

// >>> hw/skid_buf2.v
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: single clock, asynchronous active-low reset
// Notes:   full ready is registered-free; a stall downstream loses no word
`timescale 1ns/100ps
module skid_buf2 #(
  parameter W = 6
) (
  input  wire         mclk,
  input  wire         arst_n,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_q [0:1];
  reg         wp_q;
  reg         rp_q;
  reg [1:0]   cnt_q;
  wire        push;
  wire        pop;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointers and fill count
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      cnt_q    <= 2'h0;
      mem_q[0] <= {W{1'b0}};
      mem_q[1] <= {W{1'b0}};
    end else begin
      if (push) begin
        mem_q[wp_q] <= in_data;
        wp_q        <= ~wp_q;
      end
      // an emptied slot reads as zero, so an idle port shows no error
      if (pop) begin
        rp_q        <= ~rp_q;
        mem_q[rp_q] <= {W{1'b0}};
      end
      if (push & ~pop)
        cnt_q <= cnt_q + 2'h1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 2'h1;
    end
  end
endmodule // skid_buf2

// >>> verif/fx_rx_pcs_asserts.sv
// Purpose: port-level checks for the receive coding sublayer
// Assumes: single clock mclk, arst_n asynchronous active low
// Notes:   link bound counts raw detect cycles, so sync delay only helps
`timescale 1ns/100ps
`include "fx_rx_pcs_map.vh"
module fx_rx_pcs_asserts (
  input wire              mclk,
  input wire              arst_n,
  input wire              sig_detect,
  input wire              fiber_reg,
  input wire              fiber_reg_sel,
  input wire              mii_ready,
  input wire              mii_valid,
  input wire [3:0]        rxd,
  input wire              rx_dv,
  input wire              rx_er,
  input wire              crs,
  input wire              link_up,
  input wire              fiber_mode,
  input wire [15:0]       false_carrier_counter,
  input wire signed [7:0] freq_ctrl,
  input wire              stall
);
  // ********************************************************************
  // helper state
  // ********************************************************************
  reg [31:0] sd_cnt_q;
  reg        newfrm_q;

  // detect run length; frame start armed only once the buffer is empty
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sd_cnt_q <= 32'h0;
      newfrm_q <= 1'b1;
    end else begin
      sd_cnt_q <= sig_detect ? sd_cnt_q + 32'h1 : 32'h0;
      if (mii_valid && mii_ready && rx_dv)
        newfrm_q <= 1'b0;
      else if (!crs && !mii_valid)
        newfrm_q <= 1'b1;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence sel_steady;
    (fiber_reg_sel && $stable(fiber_reg)) [*4];
  endsequence
  sequence word_held;
    mii_valid && !mii_ready;
  endsequence

  chk_bad_nibble: assert property (
    mii_valid && rx_er && !rx_dv |-> rxd == 4'he) else $error("bad start nibble wrong");
  chk_hold_word: assert property (
    word_held |=> mii_valid && $stable({rxd, rx_dv, rx_er})) else $error("word lost in stall");
  chk_stall_valid: assert property (
    stall |-> mii_valid) else $error("full buffer shows no word");
  chk_count_step: assert property (
    $changed(false_carrier_counter) |->
      false_carrier_counter == $past(false_carrier_counter) + 16'h0001)
    else $error("false carrier count not single step");
  chk_link_time: assert property (
    $rose(link_up) |-> sd_cnt_q >= `LINK_UP_CYC) else $error("link up too early");
  chk_preamble_first: assert property (
    mii_valid && mii_ready && rx_dv && newfrm_q |-> rxd == 4'h5)
    else $error("frame does not open with preamble");
  chk_freq_step: assert property (
    $changed(freq_ctrl) |-> (freq_ctrl == $past(freq_ctrl) + 8'sd1) ||
      (freq_ctrl == $past(freq_ctrl) - 8'sd1)) else $error("frequency word jumped");
  chk_fiber_sel: assert property (
    sel_steady |-> fiber_mode == fiber_reg) else $error("fiber select ignored");
endmodule // fx_rx_pcs_asserts

bind fx_rx_pcs fx_rx_pcs_asserts chk (.mclk, .arst_n, .sig_detect, .fiber_reg,
  .fiber_reg_sel, .mii_ready, .mii_valid, .rxd, .rx_dv, .rx_er, .crs, .link_up,
  .fiber_mode, .false_carrier_counter, .freq_ctrl, .stall);

// >>> verif/mac_sink.sv
// Purpose: receive side of a mac taking mii nibbles
// Assumes: words accepted on valid and ready at the rising edge
// Notes:   slow halves the ready rate, hold stalls until released
`timescale 1ns/100ps
module mac_sink (
  input  wire       mclk,
  input  wire       hold,
  input  wire       slow,
  input  wire       mii_valid,
  input  wire [3:0] rxd,
  input  wire       rx_dv,
  input  wire       rx_er,
  output reg        mii_ready = 1'b0
);
  // ********************************************************************
  // capture
  // ********************************************************************
  logic [5:0] q[$];

  // record {error, data valid, nibble}; ready changes only after the edge
  always @(posedge mclk) begin
    if (mii_valid && mii_ready)
      q.push_back({rx_er, rx_dv, rxd});
    mii_ready <= !hold && !(slow && mii_ready);
  end
endmodule // mac_sink

// >>> verif/tb_top.sv
// Purpose: self-checking bench for the receive coding sublayer
// Assumes: fiber path, line bits every gap cycles, mac_sink partner
// Notes:   waiting for link dominates the run length
`timescale 1ns/100ps
`include "fx_rx_pcs_map.vh"
module tb_top;
  // ********************************************************************
  // stimulus and observation
  // ********************************************************************
  reg               mclk = 1'b0;
  reg               arst_n = 1'b0;
  reg               bit_valid = 1'b0;
  reg               rx_line = 1'b0;
  reg               strap = 1'b1;
  reg               fib = 1'b0;
  reg               fib_sel = 1'b0;
  reg               pe_valid = 1'b0;
  reg signed [7:0]  pe = 8'sd0;
  reg               hold = 1'b0;
  reg               slow = 1'b0;
  reg               sd = 1'b1;
  reg               tx_v = 1'b0;
  wire              tx_out;
  wire              ready, valid, dv, er, crs, link_up, fiber_mode, stall;
  wire [3:0]        rxd;
  wire [15:0]       fcc;
  wire signed [7:0] freq;
  integer           err_count = 0;
  integer           checks_done = 0;
  logic [4:0]       tx_q[$];
  logic [5:0]       exp_q[$];
  logic [4:0]       tbl [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                                 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

  always #2 mclk = ~mclk;

  // extend input held: the hold timer only matters on the copper path
  fx_rx_pcs dut (.mclk(mclk), .arst_n(arst_n), .bit_valid(bit_valid), .rx_line(rx_line),
    .sig_detect(sd), .fiber_strap(strap), .fiber_reg(fib), .fiber_reg_sel(fib_sel),
    .descrambler_timeout_extend(1'b0), .phase_err_valid(pe_valid), .phase_err(pe),
    .tx_bit_valid(tx_v), .tx_line_in(1'b0), .mii_ready(ready), .mii_valid(valid),
    .rxd(rxd), .rx_dv(dv), .rx_er(er), .crs(crs), .link_up(link_up), .descr_locked(),
    .fiber_mode(fiber_mode), .false_carrier_counter(fcc), .freq_ctrl(freq),
    .tx_line_out(tx_out), .stall(stall));

  mac_sink mac (.mclk(mclk), .hold(hold), .slow(slow), .mii_valid(valid), .rxd(rxd),
    .rx_dv(dv), .rx_er(er), .mii_ready(ready));

  // ********************************************************************
  // shared tasks
  // ********************************************************************
  task check(input [15:0] seen, input [15:0] want);
    begin
      checks_done = checks_done + 1;
      if (seen !== want) begin
        err_count = err_count + 1;
        $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
      end
    end
  endtask

  // nrzi: a one toggles the line; a full buffer pauses the sender
  task send_cg(input [4:0] cg, input integer gap);
    integer i;
    integer k;
    begin
      for (i = 4; i >= 0; i = i - 1) begin
        k = 0;
        while (stall === 1'b1 && k < 2000) begin
          @(negedge mclk);
          k = k + 1;
        end
        rx_line = rx_line ^ cg[i];
        bit_valid = 1'b1;
        @(negedge mclk);
        bit_valid = 1'b0;
        repeat (gap - 1) @(negedge mclk);
      end
    end
  endtask

  task play(input integer gap);
    begin
      mac.q.delete();
      while (tx_q.size() > 0)
        send_cg(tx_q.pop_front(), gap);
      repeat (100) @(negedge mclk);
    end
  endtask

  task cmp_words;
    integer i;
    begin
      for (i = 0; i < exp_q.size(); i = i + 1)
        check(mac.q[i], exp_q[i]);
    end
  endtask

  task stop_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  // ********************************************************************
  // scenarios
  // ********************************************************************
  task t_mode;
    begin
      check(fiber_mode, 1'b1);
      fib_sel = 1'b1;
      repeat (10) @(negedge mclk);
      check(fiber_mode, 1'b0);
      fib = 1'b1;
      repeat (10) @(negedge mclk);
      check(fiber_mode, 1'b1);
      $display("test mode done");
    end
  endtask

  task t_link;
    integer k;
    begin
      k = 0;
      while (link_up !== 1'b1 && k < 110000) begin
        @(negedge mclk);
        k = k + 1;
      end
      check(link_up, 1'b1);
      $display("test link done");
    end
  endtask

  task t_frame;
    integer n;
    begin
      slow = 1'b1;
      exp_q = '{6'h15, 6'h15};
      tx_q = '{5'h1f, 5'h1f, 5'h1f, 5'h1f, `CG_J, `CG_K};
      for (n = 0; n < 16; n = n + 1) begin
        tx_q.push_back(tbl[n]);
        exp_q.push_back({2'b01, n[3:0]});
      end
      tx_q = {tx_q, `CG_T, `CG_R, 5'h1f, 5'h1f, 5'h1f};
      play(2);
      cmp_words;
      check(mac.q.size(), 18);
      check(crs, 1'b0);
      slow = 1'b0;
      $display("test frame done");
    end
  endtask

  task t_bad;
    reg [15:0] c0;
    begin
      c0 = fcc;
      exp_q = '{6'h2e, 6'h2e};
      tx_q = '{5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h14, 5'h15, 5'h1f, 5'h1f, 5'h1f};
      play(2);
      cmp_words;
      check(fcc, c0 + 16'h0001);
      check({crs, er}, 2'b00);
      $display("test bad start done");
    end
  endtask

  task t_ctrl;
    begin
      tx_q = '{5'h1f, 5'h1f, 5'h1f, `CG_J, `CG_K, `CG_IDLE, 5'h0f, `CG_T, `CG_R, 5'h1f};
      play(2);
      check(mac.q[2][5:4], 2'b11);
      check(mac.q[3], 6'h17);
      $display("test control in packet done");
    end
  endtask

  task t_stall;
    reg saw;
    integer k;
    begin
      saw = 1'b0;
      hold = 1'b1;
      exp_q = '{6'h15, 6'h15, 6'h1a, 6'h1b};
      tx_q = '{5'h1f, 5'h1f, 5'h1f, `CG_J, `CG_K, 5'h16, 5'h17, `CG_T, `CG_R, 5'h1f, 5'h1f};
      fork
        play(8);
        begin
          k = 0;
          while (stall !== 1'b1 && k < 2000) begin
            @(negedge mclk);
            k = k + 1;
          end
          saw = stall;
          repeat (50) @(negedge mclk);
          hold = 1'b0;
        end
      join
      check(saw, 1'b1);
      cmp_words;
      $display("test stall done");
    end
  endtask

  task t_freq;
    integer n;
    begin
      for (n = 0; n < 4; n = n + 1) begin
        pe = (n == 3) ? -8'sd5 : 8'sd5;
        pe_valid = 1'b1;
        @(negedge mclk);
        pe_valid = 1'b0;
        repeat (3) @(negedge mclk);
      end
      check(freq, 8'sh02);
      $display("test loop filter done");
    end
  endtask

  // first zero follows a long run, so only the last three cycles count
  task t_fef;
    integer n;
    integer t;
    reg     p;
    begin
      for (n = 0; n < 68; n = n + 1)
        tx_q.push_back((n % 17 == 16) ? 5'h1e : `CG_IDLE);
      play(2);
      check(link_up, 1'b0);
      sd = 1'b0;
      repeat (4) @(negedge mclk);
      t = 0;
      tx_v = 1'b1;
      repeat (85) begin
        p = tx_out;
        @(negedge mclk);
        t = t + (tx_out ^ p);
      end
      tx_v = 1'b0;
      check(t, `FEF_ONES);
      $display("test far-end fault done");
    end
  endtask

  // main sequence: reset, then each scenario
  initial begin
    repeat (3) @(negedge mclk);
    arst_n = 1'b1;
    repeat (3) @(negedge mclk);
    t_mode;
    t_link;
    t_frame;
    t_bad;
    t_ctrl;
    t_stall;
    t_freq;
    t_fef;
    stop_test;
  end

  // watchdog: link wait plus scenarios stay well under this span
  initial begin
    repeat (130000) @(posedge mclk);
    err_count = err_count + 1;
    stop_test;
  end
endmodule // tb_top
